// >>> pfcc_defines.svh
`ifndef PFCC_DEFINES_SVH
`define PFCC_DEFINES_SVH

// Register byte offsets (own map)
`define PFCC_ADDR_CTRL 4'h0
`define PFCC_ADDR_STAT 4'h4
`define PFCC_ADDR_TOUT 4'h8
// Control fields
`define PFCC_CTRL_START 0
`define PFCC_CTRL_STOP 1
`define PFCC_CTRL_PEAK_HI 2
`define PFCC_CTRL_FIRE 3
`define PFCC_CTRL_MOTOR 4
`define PFCC_CTRL_WEAK 5
// Status fields
`define PFCC_STAT_BUSY 0
`define PFCC_STAT_DONE 1
`define PFCC_STAT_OVP 2
`define PFCC_STAT_REQ 3
`define PFCC_STAT_DONE_PIN 4
// Default charge timeout in milliseconds
`define PFCC_TOUT_MS 32'd10000
`define PFCC_CLK_MHZ 32'd125
`define PFCC_TOUT_RST (`PFCC_TOUT_MS * `PFCC_CLK_MHZ * 32'd1000)
`define PFCC_RESP_OKAY 2'b00
`define PFCC_RESP_SLVERR 2'b10

`endif

// >>> pfcc_pkg.sv
package pfcc_pkg;
  typedef enum logic [1:0] {
    PFCC_IDLE,
    PFCC_CHARGING,
    PFCC_DONE,
    PFCC_FAULT
  } pfcc_state_t;

  typedef struct packed {
    logic charge_request;
    logic flash_gate;
    logic peak_select;
  } pfcc_pins_t;
endpackage

// >>> pfcc_axil.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfcc_defines.svh"

// ----------------------------------------
// AXI4-Lite slave, one write and one read in flight
// ----------------------------------------
module pfcc_axil
  import pfcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [3:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic wr_pulse_out,
  output logic [3:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic [3:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr;

  assign awready_out = !aw_have_q && !bvalid_out;
  assign wready_out = !w_have_q && !bvalid_out;
  assign do_wr = aw_have_q && w_have_q && !bvalid_out;
  assign wr_pulse_out = do_wr;
  assign wr_addr_out = awaddr_q;
  assign wr_data_out = wdata_q;
  assign wr_strb_out = wstrb_q;
  assign arready_out = !rvalid_out;
  assign rd_addr_out = araddr_in;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr_in;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata_in;
        wstrb_q <= wstrb_in;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= `PFCC_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_ok_in ? `PFCC_RESP_OKAY : `PFCC_RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= `PFCC_RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      rvalid_out <= 1'b1;
      rdata_out <= rd_ok_in ? rd_data_in : 32'h0000_0000;
      rresp_out <= rd_ok_in ? `PFCC_RESP_OKAY : `PFCC_RESP_SLVERR;
    end else if (rready_in) begin
      rvalid_out <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// >>> pfcc_ctrl.sv
// Function
// - Dropping charge_request low stops charging at once.
// - charge_done_n is open-drain; controller provides the pull-up (pfcc_ctrl has none; the testbench models it).
// - Controller times each charge; timeout means over-voltage, drop request.
// - Controller picks lower peak during motor use or weak battery.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pfcc_defines.svh"

module pfcc_ctrl
  import pfcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] s_axil_awaddr_in,
  input wire logic s_axil_awvalid_in,
  output logic s_axil_awready_out,
  input wire logic [31:0] s_axil_wdata_in,
  input wire logic [3:0] s_axil_wstrb_in,
  input wire logic s_axil_wvalid_in,
  output logic s_axil_wready_out,
  output logic [1:0] s_axil_bresp_out,
  output logic s_axil_bvalid_out,
  input wire logic s_axil_bready_in,
  input wire logic [3:0] s_axil_araddr_in,
  input wire logic s_axil_arvalid_in,
  output logic s_axil_arready_out,
  output logic [31:0] s_axil_rdata_out,
  output logic [1:0] s_axil_rresp_out,
  output logic s_axil_rvalid_out,
  input wire logic s_axil_rready_in,
  output logic charge_request_out,
  output logic flash_fire_out,
  output logic peak_select_out,
  input wire logic charge_done_n_in
);
  // ----------------------------------------
  // Register decode helpers
  // ----------------------------------------
  function automatic logic addr_known(input logic [3:0] a);
    addr_known = (a == `PFCC_ADDR_CTRL) || (a == `PFCC_ADDR_STAT) || (a == `PFCC_ADDR_TOUT);
  endfunction

  logic wr_pulse;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;

  pfcc_axil u_bus (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .awaddr_in(s_axil_awaddr_in),
    .awvalid_in(s_axil_awvalid_in),
    .awready_out(s_axil_awready_out),
    .wdata_in(s_axil_wdata_in),
    .wstrb_in(s_axil_wstrb_in),
    .wvalid_in(s_axil_wvalid_in),
    .wready_out(s_axil_wready_out),
    .bresp_out(s_axil_bresp_out),
    .bvalid_out(s_axil_bvalid_out),
    .bready_in(s_axil_bready_in),
    .araddr_in(s_axil_araddr_in),
    .arvalid_in(s_axil_arvalid_in),
    .arready_out(s_axil_arready_out),
    .rdata_out(s_axil_rdata_out),
    .rresp_out(s_axil_rresp_out),
    .rvalid_out(s_axil_rvalid_out),
    .rready_in(s_axil_rready_in),
    .wr_pulse_out(wr_pulse),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(addr_known(wr_addr)),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(addr_known(rd_addr))
  );

  // ----------------------------------------
  // Control and timeout registers
  // ----------------------------------------
  logic wr_ctrl;
  logic wr_tout;
  logic start_cmd;
  logic stop_cmd;
  logic peak_hi_q;
  logic fire_q;
  logic motor_q;
  logic weak_q;
  logic [31:0] tout_q;

  assign wr_ctrl = wr_pulse && (wr_addr == `PFCC_ADDR_CTRL) && wr_strb[0];
  assign wr_tout = wr_pulse && (wr_addr == `PFCC_ADDR_TOUT);
  assign start_cmd = wr_ctrl && wr_data[`PFCC_CTRL_START];
  assign stop_cmd = wr_ctrl && wr_data[`PFCC_CTRL_STOP];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      peak_hi_q <= 1'b0;
      fire_q <= 1'b0;
      motor_q <= 1'b0;
      weak_q <= 1'b0;
    end else if (wr_ctrl) begin
      peak_hi_q <= wr_data[`PFCC_CTRL_PEAK_HI];
      fire_q <= wr_data[`PFCC_CTRL_FIRE];
      motor_q <= wr_data[`PFCC_CTRL_MOTOR];
      weak_q <= wr_data[`PFCC_CTRL_WEAK];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tout_lane
      always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
          tout_q[gi*8 +: 8] <= 8'(`PFCC_TOUT_RST >> (gi*8));
        end else if (wr_tout && wr_strb[gi]) begin
          tout_q[gi*8 +: 8] <= wr_data[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Charge sequencing
  // ----------------------------------------
  pfcc_state_t state_q;
  logic [31:0] timer_q;
  logic done_seen;
  logic timed_out;

  // Pin is open-drain with pull-up: low means charged
  assign done_seen = !charge_done_n_in;
  assign timed_out = (timer_q >= tout_q);

  // A new start always passes through IDLE so the device sees a fresh rising edge
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= PFCC_IDLE;
    end else begin
      case (state_q)
        PFCC_IDLE: begin
          if (start_cmd && !stop_cmd) begin
            state_q <= PFCC_CHARGING;
          end
        end
        PFCC_CHARGING: begin
          if (stop_cmd) begin
            state_q <= PFCC_IDLE;
          end else if (done_seen) begin
            state_q <= PFCC_DONE;
          end else if (timed_out) begin
            // Done never comes after an over-voltage stop
            state_q <= PFCC_FAULT;
          end
        end
        PFCC_DONE, PFCC_FAULT: begin
          if (start_cmd || stop_cmd) begin
            state_q <= PFCC_IDLE;
          end
        end
        default: state_q <= PFCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      timer_q <= 32'h0000_0000;
    end else if (state_q == PFCC_CHARGING) begin
      timer_q <= timer_q + 32'h0000_0001;
    end else begin
      timer_q <= 32'h0000_0000;
    end
  end

  // Sticky result flags; cleared by a new start, but a set wins
  logic done_flag_q;
  logic ovp_flag_q;
  logic set_done;
  logic set_ovp;

  assign set_done = (state_q == PFCC_CHARGING) && !stop_cmd && done_seen;
  assign set_ovp = (state_q == PFCC_CHARGING) && !stop_cmd && !done_seen && timed_out;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      done_flag_q <= 1'b0;
      ovp_flag_q <= 1'b0;
    end else begin
      done_flag_q <= set_done || (done_flag_q && !start_cmd);
      ovp_flag_q <= set_ovp || (ovp_flag_q && !start_cmd);
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      charge_request_out <= 1'b0;
      flash_fire_out <= 1'b0;
      peak_select_out <= 1'b0;
    end else begin
      // Request stays high through DONE so the device holds done; FAULT drops it
      charge_request_out <= (state_q == PFCC_CHARGING) || (state_q == PFCC_DONE);
      flash_fire_out <= fire_q;
      // Motor or weak battery forces the lower peak to protect the supply
      peak_select_out <= peak_hi_q && !motor_q && !weak_q;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `PFCC_ADDR_CTRL: begin
        rd_data[`PFCC_CTRL_PEAK_HI] = peak_hi_q;
        rd_data[`PFCC_CTRL_FIRE] = fire_q;
        rd_data[`PFCC_CTRL_MOTOR] = motor_q;
        rd_data[`PFCC_CTRL_WEAK] = weak_q;
      end
      `PFCC_ADDR_STAT: begin
        rd_data[`PFCC_STAT_BUSY] = (state_q == PFCC_CHARGING);
        rd_data[`PFCC_STAT_DONE] = done_flag_q;
        rd_data[`PFCC_STAT_OVP] = ovp_flag_q;
        rd_data[`PFCC_STAT_REQ] = charge_request_out;
        rd_data[`PFCC_STAT_DONE_PIN] = charge_done_n_in;
      end
      `PFCC_ADDR_TOUT: rd_data = tout_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end
endmodule

`default_nettype wire

// >>> pfcc_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module pfcc_ctrl_asserts #(
  parameter int MAX_HIGH = 64
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic s_axil_bvalid_out,
  input wire logic s_axil_bready_in,
  input wire logic s_axil_rvalid_out,
  input wire logic s_axil_rready_in,
  input wire logic s_axil_arready_out,
  input wire logic charge_request_out,
  input wire logic charge_done_n_in
);
  logic [15:0] wait_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Bench programs a short timeout, so a hung request shows here
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !charge_request_out || !charge_done_n_in) begin
      wait_q <= 16'h0000;
    end else begin
      wait_q <= wait_q + 16'h0001;
    end
  end
  property p_timeout; wait_q <= MAX_HIGH; endproperty
  a_timeout: assert property (p_timeout) else $error("request held past timeout");
  property p_rise; $rose(charge_request_out) |-> $past(s_axil_bvalid_out); endproperty
  a_rise: assert property (p_rise) else $error("request rose without a write");
  property p_rst; $rose(resetn_in) |-> !charge_request_out; endproperty
  a_rst: assert property (p_rst) else $error("request high after reset");
  property p_bhold; s_axil_bvalid_out && !s_axil_bready_in |=> s_axil_bvalid_out; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axil_rvalid_out && !s_axil_rready_in |=> s_axil_rvalid_out; endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_arrdy; s_axil_rvalid_out |-> !s_axil_arready_out; endproperty
  a_arrdy: assert property (p_arrdy) else $error("read taken while busy");
  c_rise: cover property ($rose(charge_request_out));
  c_fall: cover property ($fell(charge_request_out));
  c_done: cover property (charge_request_out && !charge_done_n_in);
endmodule

bind pfcc_ctrl pfcc_ctrl_asserts u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .s_axil_bvalid_out(s_axil_bvalid_out), .s_axil_bready_in(s_axil_bready_in),
  .s_axil_rvalid_out(s_axil_rvalid_out), .s_axil_rready_in(s_axil_rready_in),
  .s_axil_arready_out(s_axil_arready_out), .charge_request_out(charge_request_out),
  .charge_done_n_in(charge_done_n_in));
`default_nettype wire

// >>> pfcc_dev_model.sv
`timescale 1ns/100ps
`default_nettype none

module pfcc_dev_model (
  input wire logic charge_request_in,
  input wire logic fire_in,
  input wire logic peak_select_in,
  input wire logic full_in,
  input wire logic ovp_in,
  input wire logic zero_in,
  input wire logic peak_in,
  input wire logic max_on_in,
  input wire logic hot_in,
  output logic done_pull_out,
  output logic gate_out,
  output logic latch_out,
  output logic peak_hi_out,
  output logic power_transistor_out
);
  logic enable_latch = 1'b0;
  logic done_low = 1'b0;
  logic ovp_hit = 1'b0;
  logic power_transistor = 1'b0;
  always @(posedge charge_request_in) begin
    enable_latch = 1'b1;
    done_low = 1'b0;
    ovp_hit = 1'b0;
    power_transistor = 1'b1;
  end
  always @(negedge charge_request_in) begin
    enable_latch = 1'b0;
    done_low = 1'b0;
  end
  // A stopped charge never flags done, so an over-voltage stop stays silent
  always @(posedge full_in) begin
    if (enable_latch && !ovp_hit) begin
      enable_latch = 1'b0;
      done_low = 1'b1;
    end
  end
  always @(posedge ovp_in) begin
    enable_latch = 1'b0;
    ovp_hit = 1'b1;
  end
  // Overheat only blocks switching; the latch survives so charging resumes on cooling
  always @(posedge zero_in) begin
    if (enable_latch && !hot_in) begin
      power_transistor = 1'b1;
    end
  end
  always @(posedge peak_in or posedge max_on_in or posedge hot_in) begin
    power_transistor = 1'b0;
  end
  assign power_transistor_out = power_transistor && enable_latch;
  assign done_pull_out = done_low;
  assign gate_out = fire_in;
  assign peak_hi_out = peak_select_in;
  assign latch_out = enable_latch;
endmodule
`default_nettype wire

// >>> photo_flash_charge_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfcc_defines.svh"

module photo_flash_charge_control_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rd, val;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, fe = 1'b0, oe = 1'b0;
  logic ze = 1'b0, pe = 1'b0, me = 1'b0, he = 1'b0;
  logic [3:0] ws = 4'hf;
  logic awr, wr, bv, arr, rv, req, fire, peak, pull, gate, en, pk, sw;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] ctl [4] = '{32'h0c, 32'h14, 32'h2c, 32'h04};
  wire logic done_n;
  int err_count = 0, check_count = 0, cyc = 0;

  assign done_n = pull ? 1'b0 : 1'b1; // Pull-up when released
  always #4 clk_in = ~clk_in;

  pfcc_ctrl i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .s_axil_awaddr_in(awa), .s_axil_awvalid_in(awv),
    .s_axil_awready_out(awr), .s_axil_wdata_in(wd), .s_axil_wstrb_in(ws), .s_axil_wvalid_in(wv),
    .s_axil_wready_out(wr), .s_axil_bresp_out(bresp), .s_axil_bvalid_out(bv), .s_axil_bready_in(bre),
    .s_axil_araddr_in(ara), .s_axil_arvalid_in(arv), .s_axil_arready_out(arr), .s_axil_rdata_out(rd),
    .s_axil_rresp_out(rresp), .s_axil_rvalid_out(rv), .s_axil_rready_in(rre), .charge_request_out(req),
    .flash_fire_out(fire), .peak_select_out(peak), .charge_done_n_in(done_n));
  pfcc_dev_model i_dev (.charge_request_in(req), .fire_in(fire), .peak_select_in(peak), .full_in(fe),
    .ovp_in(oe), .zero_in(ze), .peak_in(pe), .max_on_in(me), .hot_in(he), .done_pull_out(pull),
    .gate_out(gate), .latch_out(en), .peak_hi_out(pk), .power_transistor_out(sw));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = bresp;
    bre <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_in);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    val = rd;
    resp = rresp;
    rre <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    chk("idle pins", {28'h0, req, fire, peak, en}, 32'h0);
    rd_reg(`PFCC_ADDR_TOUT);
    chk("tout reset", val, `PFCC_TOUT_RST);
    rd_reg(4'hc);
    chk("bad read", {resp, val[29:0]}, {`PFCC_RESP_SLVERR, 30'h0});
    wr_reg(4'hc, 32'hffff_ffff);
    chk("bad write", {30'h0, resp}, {30'h0, `PFCC_RESP_SLVERR});
    wr_reg(`PFCC_ADDR_TOUT, 32'h32);
    rd_reg(`PFCC_ADDR_TOUT);
    chk("tout", val, 32'h32);
    ws <= 4'h1;
    wr_reg(`PFCC_ADDR_TOUT, 32'hffff_ff31);
    ws <= 4'hf;
    rd_reg(`PFCC_ADDR_TOUT);
    chk("tout lane", val, 32'h31);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`PFCC_ADDR_CTRL, ctl[i]);
      @(posedge clk_in);
      chk("gate", {31'h0, gate}, {31'h0, ctl[i][3]});
      chk("peak", {31'h0, pk}, {31'h0, ctl[i][2] & ~ctl[i][4] & ~ctl[i][5]});
    end
    wr_reg(`PFCC_ADDR_CTRL, 32'h1);
    @(posedge clk_in);
    chk("start", {30'h0, req, en}, 32'h3);
    fe <= 1'b1;
    @(posedge clk_in);
    fe <= 1'b0;
    rd_reg(`PFCC_ADDR_STAT);
    chk("full stat", val & 32'h1e, 32'h0a);
    chk("full latch", {31'h0, en}, 32'h0);
    wr_reg(`PFCC_ADDR_CTRL, 32'h1);
    @(posedge clk_in);
    chk("leave done", {30'h0, req, done_n}, 32'h1);
    wr_reg(`PFCC_ADDR_CTRL, 32'h1);
    @(posedge clk_in);
    chk("recharge", {29'h0, req, en, sw}, 32'h7);
    pe <= 1'b1;
    @(posedge clk_in);
    pe <= 1'b0;
    @(posedge clk_in);
    chk("sw peak off", {31'h0, sw}, 32'h0);
    ze <= 1'b1;
    @(posedge clk_in);
    ze <= 1'b0;
    @(posedge clk_in);
    chk("sw zero on", {31'h0, sw}, 32'h1);
    me <= 1'b1;
    @(posedge clk_in);
    me <= 1'b0;
    he <= 1'b1;
    @(posedge clk_in);
    chk("sw max on", {31'h0, sw}, 32'h0);
    ze <= 1'b1;
    @(posedge clk_in);
    ze <= 1'b0;
    he <= 1'b0;
    @(posedge clk_in);
    chk("hot hold", {30'h0, sw, en}, 32'h1);
    ze <= 1'b1;
    @(posedge clk_in);
    ze <= 1'b0;
    @(posedge clk_in);
    chk("cool resume", {30'h0, sw, en}, 32'h3);
    wr_reg(`PFCC_ADDR_CTRL, 32'h3);
    @(posedge clk_in);
    chk("stop", {29'h0, req, en, sw}, 32'h0);
    wr_reg(`PFCC_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clk_in);
    oe <= 1'b1;
    @(posedge clk_in);
    oe <= 1'b0;
    repeat (60) @(posedge clk_in);
    chk("fault pins", {30'h0, req, done_n}, 32'h1);
    rd_reg(`PFCC_ADDR_STAT);
    chk("fault stat", val & 32'h1e, 32'h14);
    wr_reg(`PFCC_ADDR_CTRL, 32'h1);
    wr_reg(`PFCC_ADDR_CTRL, 32'h1);
    rd_reg(`PFCC_ADDR_STAT);
    chk("new charge", val & 32'h1e, 32'h18);
    wr_reg(`PFCC_ADDR_CTRL, 32'h2);
    summarize();
  end
endmodule
`default_nettype wire
